// File: rtl/pix_out.sv
// Pixel output stage: cursor vertical gating, hi-res cursor merge, LCD grey-scale packing
`timescale 1ns/10ps
`default_nettype none
module pix_out (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire pix_out_pkg::pix_in_type pix_in,
  input  wire logic                    display_active,
  input  wire logic                    border_active,
  input  wire logic                    line_start,
  input  wire logic                    vertical_flyback,
  input  wire logic [1:0]              port_byte_select_in,
  output logic [7:0]                   ext_data_port,
  output logic                         ext_port_clock,
  output logic [1:0]                   port_byte_select,
  output logic                         cursor_upper_en,
  output logic                         cursor_lower_en
);
  logic [31:0]                  ext_q;
  logic [31:0]                  ctrl_q;
  logic [31:0]                  vcs_q;
  logic [31:0]                  vce_q;
  logic [7:0]                   border_q;
  logic [1:0]                   sel_meta_q;
  logic [1:0]                   sel_q;
  logic [pix_out_pkg::RASTER_W-1:0] raster_q;
  logic                         flyback_d1_q;
  logic                         field_odd_q;
  logic                         seen_even_q;
  logic [1:0]                   col_q;
  logic [1:0]                   phase_q;
  logic [3:0]                   up_sr_q;
  logic [3:0]                   low_sr_q;
  logic [7:0]                   lcd_nib_q;
  logic [7:0]                   hires_q;
  logic [3:0]                   ext_d1_q;
  logic [7:0]                   port_q;
  logic                         port_clk_q;
  logic                         cur_up_q;
  logic                         cur_low_q;
  logic                         wr_en;
  logic                         mapped;
  logic                         lcd;
  logic                         hrm;
  logic                         dup;
  logic                         ilc;
  logic [2:0]                   bpp;
  logic [1:0]                   panel;
  logic                         grey_ok;
  logic                         up_bit;
  logic                         low_bit;
  logic                         in_win;
  logic                         lower_win;
  logic                         upper_win;
  logic [7:0]                   hires_mix;
  logic                         retrace_start;
  logic [pix_out_pkg::RASTER_W-1:0] vcs_val;
  logic [pix_out_pkg::RASTER_W-1:0] vce_val;

  assign lcd   = ext_q[pix_out_pkg::EXT_LCD_BIT];
  assign hrm   = ext_q[pix_out_pkg::EXT_HRM_BIT];
  assign dup   = ctrl_q[pix_out_pkg::CTRL_DUP_BIT];
  assign ilc   = ctrl_q[pix_out_pkg::CTRL_ILC_BIT];
  assign bpp   = ctrl_q[pix_out_pkg::CTRL_BPP_LSB +: 3];
  assign panel = vcs_q[pix_out_pkg::VCS_SEL_LSB +: 2];
  assign vcs_val = vcs_q[pix_out_pkg::RASTER_W-1:0];
  assign vce_val = vce_q[pix_out_pkg::RASTER_W-1:0];
  // Dithering is defined only for palette-mapped depths; deeper modes pass green raw on one panel
  assign grey_ok = (bpp <= pix_out_pkg::BPP_4);

  // APB slave: zero wait states, error on unmapped offsets
  assign mapped = (paddr == pix_out_pkg::OFS_EXT) || (paddr == pix_out_pkg::OFS_CTRL) ||
                  (paddr == pix_out_pkg::OFS_VCS) || (paddr == pix_out_pkg::OFS_VCE) ||
                  (paddr == pix_out_pkg::OFS_BORDER) || (paddr == pix_out_pkg::OFS_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      pix_out_pkg::OFS_EXT:    prdata = ext_q;
      pix_out_pkg::OFS_CTRL:   prdata = ctrl_q;
      pix_out_pkg::OFS_VCS:    prdata = vcs_q;
      pix_out_pkg::OFS_VCE:    prdata = vce_q;
      pix_out_pkg::OFS_BORDER: prdata = {24'h00_0000, border_q};
      pix_out_pkg::OFS_STATUS: prdata = {16'h0000, field_odd_q, seen_even_q, 1'b0, raster_q};
      default:                 prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q    <= pix_out_pkg::EXT_RST;
      ctrl_q   <= pix_out_pkg::CTRL_RST;
      vcs_q    <= pix_out_pkg::VC_RST;
      vce_q    <= pix_out_pkg::VC_RST;
      border_q <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        pix_out_pkg::OFS_EXT:    ext_q    <= pwdata;
        pix_out_pkg::OFS_CTRL:   ctrl_q   <= pwdata;
        pix_out_pkg::OFS_VCS:    vcs_q    <= {17'h0_0000, pwdata[14:0]};
        pix_out_pkg::OFS_VCE:    vce_q    <= {19'h0_0000, pwdata[12:0]};
        pix_out_pkg::OFS_BORDER: border_q <= pwdata[7:0];
        default:                 border_q <= border_q;
      endcase
    end
  end

  // Byte select pins are asynchronous to the pixel clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_meta_q <= 2'h0;
      sel_q      <= 2'h0;
    end else begin
      sel_meta_q <= port_byte_select_in;
      sel_q      <= sel_meta_q;
    end
  end

  // Selector field ext_q[1:0] driven out so that outside logic may loop it back
  assign port_byte_select = ext_q[1:0];

  // Raster and field tracking
  assign retrace_start = vertical_flyback && !flyback_d1_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flyback_d1_q <= 1'b0;
      raster_q     <= '0;
      field_odd_q  <= 1'b0;
      seen_even_q  <= 1'b0;
    end else begin
      flyback_d1_q <= vertical_flyback;
      if (vertical_flyback)
        raster_q <= '0;
      else if (line_start)
        raster_q <= raster_q + 1'b1;
      if (!ilc) begin
        field_odd_q <= 1'b0;
        seen_even_q <= 1'b0;
      end else if (retrace_start) begin
        field_odd_q <= !field_odd_q;
        // The cursor pointer is only reloaded before an even field, so no start before one
        if (field_odd_q)
          seen_even_q <= 1'b1;
      end
    end
  end

  // Cursor vertical windows per panel
  assign in_win    = (raster_q >= vcs_val) && (raster_q < vce_val);
  assign lower_win = (raster_q < vcs_val);
  assign upper_win = (raster_q >= vce_val);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_up_q  <= 1'b0;
      cur_low_q <= 1'b0;
    end else if (vertical_flyback || (ilc && !seen_even_q)) begin
      // No cursor during vertical flyback; interlace waits for an even field start
      cur_up_q  <= 1'b0;
      cur_low_q <= 1'b0;
    end else if (dup) begin
      case (panel)
        pix_out_pkg::PANEL_UPPER: begin
          cur_up_q  <= in_win;
          cur_low_q <= 1'b0;
        end
        pix_out_pkg::PANEL_LOWER: begin
          cur_up_q  <= 1'b0;
          cur_low_q <= in_win;
        end
        pix_out_pkg::PANEL_SPLIT: begin
          cur_up_q  <= upper_win;
          cur_low_q <= lower_win;
        end
        default: begin
          cur_up_q  <= 1'b0;
          cur_low_q <= 1'b0;
        end
      endcase
    end else begin
      // Same window both fields keeps equal cursor rasters per field
      cur_up_q  <= in_win;
      cur_low_q <= 1'b0;
    end
  end

  assign cursor_upper_en = cur_up_q;
  assign cursor_lower_en = cur_low_q;

  // Grey-scaling: cursor colours already arrive through the cursor palette upstream,
  // so both streams see cursor and video alike
  grey_dither u_up (
    .shade   (pix_in.green[3:0]),
    .row     (raster_q[1:0]),
    .col     (col_q),
    .bit_out (up_bit)
  );

  grey_dither u_low (
    .shade   (pix_in.ext),
    .row     (raster_q[1:0]),
    .col     (col_q),
    .bit_out (low_bit)
  );

  // Column phase restarts each line so nibbles align to the first displayed pixel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_q     <= 2'h0;
      phase_q   <= 2'h0;
      up_sr_q   <= 4'h0;
      low_sr_q  <= 4'h0;
      lcd_nib_q <= 8'h00;
    end else if (!display_active) begin
      col_q   <= 2'h0;
      phase_q <= 2'h0;
    end else begin
      col_q    <= col_q + 2'h1;
      phase_q  <= phase_q + 2'h1;
      up_sr_q  <= {up_sr_q[2:0], up_bit};
      low_sr_q <= {low_sr_q[2:0], low_bit};
      if (phase_q == pix_out_pkg::PHASE_LAST) begin
        // First pixel shifted furthest ends on bit 7
        if (!grey_ok)
          lcd_nib_q <= dup ? 8'h00 : pix_in.green;
        else if (dup)
          lcd_nib_q <= {up_sr_q[2:0], up_bit, low_sr_q[2:0], low_bit};
        else
          lcd_nib_q <= {up_sr_q[2:0], up_bit, 4'h0};
      end
    end
  end

  // Hi-res cursor merge, per bit pair
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pair
      assign hires_mix[2*gi+1 -: 2] = pix_in.cursor[2*gi] ? {2{pix_in.cursor[2*gi+1]}}
                                                          : pix_in.blue[2*gi+1 -: 2];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hires_q  <= 8'h00;
      ext_d1_q <= 4'h0;
    end else begin
      // Border overrides the cursor; cursor palette plays no part here
      hires_q  <= border_active ? border_q : hires_mix;
      ext_d1_q <= pix_in.ext;
    end
  end

  // External port mux, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_q <= 8'h00;
    end else begin
      case (sel_q)
        pix_out_pkg::SEL_RED:   port_q <= pix_in.red;
        pix_out_pkg::SEL_GREEN: port_q <= lcd ? lcd_nib_q : pix_in.green;
        pix_out_pkg::SEL_BLUE:  port_q <= hrm ? hires_q : pix_in.blue;
        default: begin
          if (ext_q[pix_out_pkg::EXT_DAC_BIT])
            port_q <= {ext_q[pix_out_pkg::EXT_DC_LSB +: 4], ext_d1_q};
          else
            port_q <= {ext_q[pix_out_pkg::EXT_DC_LSB +: 4], pix_in.ext};
        end
      endcase
    end
  end

  assign ext_data_port = port_q;

  // Port clock: off unless enabled; a pixel-rate toggle in hi-res, quarter rate in LCD.
  // The toggle gives one edge per pixel, since the pixel clock itself cannot leave a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_clk_q <= 1'b0;
    end else if (!ext_q[pix_out_pkg::EXT_PCKE_BIT]) begin
      port_clk_q <= 1'b0;
    end else if (lcd) begin
      port_clk_q <= display_active && phase_q[1];
    end else begin
      port_clk_q <= !port_clk_q;
    end
  end

  assign ext_port_clock = port_clk_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hires_pair_a: assert property (
    (sel_q == pix_out_pkg::SEL_BLUE && hrm && !border_active && pix_in.cursor[0])
      ##1 (sel_q == pix_out_pkg::SEL_BLUE && hrm) |=> port_q[1:0] == {2{$past(pix_in.cursor[1], 2)}})
    else $error("hi-res cursor pair not forced");
  hires_pass_a: assert property (
    (sel_q == pix_out_pkg::SEL_BLUE && hrm && !border_active && pix_in.cursor == 8'h00)
      ##1 (sel_q == pix_out_pkg::SEL_BLUE && hrm) |=> port_q == $past(pix_in.blue, 2))
    else $error("hi-res blue not delayed two cycles");
  border_blue_a: assert property (
    (border_active && sel_q == pix_out_pkg::SEL_BLUE && hrm) ##1 (sel_q == pix_out_pkg::SEL_BLUE && hrm)
      |=> port_q == $past(border_q, 2))
    else $error("border colour missing in hi-res");
  single_low_a: assert property (
    (display_active && !dup && grey_ok && phase_q == pix_out_pkg::PHASE_LAST) |=> lcd_nib_q[3:0] == 4'h0)
    else $error("single panel low nibble not zero");
  nibble_rate_a: assert property (
    (display_active && phase_q == pix_out_pkg::PHASE_LAST) |=> display_active [*3] |-> $stable(lcd_nib_q))
    else $error("nibble changed inside a quad");
  first_pixel_a: assert property (
    (display_active && phase_q == 2'h0 && grey_ok) ##1 display_active [*3]
      |=> lcd_nib_q[7] == $past(up_bit, 4))
    else $error("first pixel not on bit 7");
  split_panel_a: assert property (
    (dup && panel == pix_out_pkg::PANEL_SPLIT && !vertical_flyback && !ilc && !line_start && !wr_en)
      |=> cursor_lower_en == (raster_q < vcs_val) && cursor_upper_en == (raster_q >= vce_val))
    else $error("split cursor window wrong");
  upper_only_a: assert property (
    (dup && panel == pix_out_pkg::PANEL_UPPER) |=> !cursor_lower_en)
    else $error("upper-panel cursor leaked to lower");
  odd_start_a: assert property (
    (ilc && !seen_even_q) |=> !cursor_upper_en && !cursor_lower_en)
    else $error("cursor shown before an even field");
  field_toggle_a: assert property (
    (ilc && retrace_start) |=> field_odd_q != $past(field_odd_q))
    else $error("field parity did not toggle");
  port_clk_idle_a: assert property (
    (ext_q[pix_out_pkg::EXT_PCKE_BIT] && lcd && !display_active) |=> !ext_port_clock)
    else $error("LCD clock ran outside display");

  hires_cov: cover property (sel_q == pix_out_pkg::SEL_BLUE && hrm && pix_in.cursor != 8'h00);
  duplex_cov: cover property (dup && lcd && display_active && phase_q == pix_out_pkg::PHASE_LAST);
  split_cov: cover property (dup && panel == pix_out_pkg::PANEL_SPLIT && cursor_upper_en);
  ilc_cov: cover property (ilc && seen_even_q && cursor_upper_en);
endmodule // pix_out
`default_nettype wire

// File: rtl/pix_out_pkg.sv
// Constants and carrier types for the cursor, LCD and hi-res pixel output block
`default_nettype none
package pix_out_pkg;
  localparam logic [7:0]  OFS_EXT      = 8'h00;
  localparam logic [7:0]  OFS_CTRL     = 8'h04;
  localparam logic [7:0]  OFS_VCS      = 8'h08;
  localparam logic [7:0]  OFS_VCE      = 8'h0C;
  localparam logic [7:0]  OFS_BORDER   = 8'h10;
  localparam logic [7:0]  OFS_STATUS   = 8'h14;
  localparam int          EXT_PCKE_BIT = 2;
  localparam int          EXT_HRM_BIT  = 12;
  localparam int          EXT_LCD_BIT  = 13;
  localparam int          EXT_DAC_BIT  = 14;
  localparam int          EXT_DC_LSB   = 4;
  localparam int          CTRL_DUP_BIT = 13;
  localparam int          CTRL_ILC_BIT = 14;
  localparam int          CTRL_BPP_LSB = 0;
  localparam int          VCS_SEL_LSB  = 13;
  localparam int          RASTER_W     = 13;
  localparam logic [31:0] EXT_RST      = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] VC_RST       = 32'h0000_0000;
  localparam logic [2:0]  BPP_1        = 3'h0;
  localparam logic [2:0]  BPP_4        = 3'h2;
  localparam logic [2:0]  BPP_32       = 3'h5;
  localparam logic [1:0]  PANEL_UPPER  = 2'h2;
  localparam logic [1:0]  PANEL_LOWER  = 2'h1;
  localparam logic [1:0]  PANEL_SPLIT  = 2'h3;
  localparam logic [1:0]  SEL_RED      = 2'h0;
  localparam logic [1:0]  SEL_GREEN    = 2'h1;
  localparam logic [1:0]  SEL_BLUE     = 2'h2;
  localparam logic [1:0]  PHASE_LAST   = 2'h3;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [3:0] ext;
    logic [7:0] cursor;
  } pix_in_type;
endpackage
`default_nettype wire

// File: rtl/grey_dither.sv
// Ordered-dither grey-scaler: one 4-bit shade to one modulated bit
`timescale 1ns/10ps
`default_nettype none
module grey_dither (
  input  wire logic [3:0] shade,
  input  wire logic [1:0] row,
  input  wire logic [1:0] col,
  output logic            bit_out
);
  logic [3:0] thresh;

  // 4x4 Bayer matrix: over a 4x4 tile exactly `shade` of 16 cells are high
  always_comb begin
    case ({row, col})
      4'h0: thresh = 4'h0;  4'h1: thresh = 4'h8;  4'h2: thresh = 4'h2;  4'h3: thresh = 4'hA;
      4'h4: thresh = 4'hC;  4'h5: thresh = 4'h4;  4'h6: thresh = 4'hE;  4'h7: thresh = 4'h6;
      4'h8: thresh = 4'h3;  4'h9: thresh = 4'hB;  4'hA: thresh = 4'h1;  4'hB: thresh = 4'h9;
      4'hC: thresh = 4'hF;  4'hD: thresh = 4'h7;  4'hE: thresh = 4'hD;  default: thresh = 4'h5;
    endcase
  end

  assign bit_out = (shade > thresh);
endmodule // grey_dither
`default_nettype wire

// File: tb/panel_model.sv
// Far-side model: select pins looped back from the port select outputs, LCD clock edge counter
`timescale 1ns/10ps
`default_nettype none
module panel_model (
  input  wire logic       pclk,
  input  wire logic [1:0] port_byte_select,
  input  wire logic       ext_port_clock,
  output logic [1:0]      port_byte_select_in,
  output int              clk_rises
);
  logic clk_seen_q;
  int   rises_q = 0;

  // Select outputs wired to the select pins, so the block steers its own port
  assign port_byte_select_in = port_byte_select;
  assign clk_rises = rises_q;

  // The panel latches on each rising port clock; counting them checks the beat rate
  always @(posedge pclk) begin
    clk_seen_q <= ext_port_clock;
    if (ext_port_clock && !clk_seen_q) begin
      rises_q <= rises_q + 1;
    end
  end
endmodule // panel_model
`default_nettype wire

// File: tb/tb_cursor_lcd_hires_output.sv
// Self-checking bench for the cursor, LCD and hi-res pixel output block
`timescale 1ns/10ps
`default_nettype none
module tb_cursor_lcd_hires_output;
  logic                    pclk, presetn, psel, penable, pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata;
  logic                    pready, pslverr;
  pix_out_pkg::pix_in_type pix_in;
  logic                    display_active, border_active, line_start, vertical_flyback;
  logic [1:0]              pbs_in, pbs_out;
  logic [7:0]              ext_data_port;
  logic                    ext_port_clock, cursor_upper_en, cursor_lower_en;
  int                      clk_rises, error_cnt, n_compared, cycles;

  pix_out dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_in(pix_in),
    .display_active(display_active), .border_active(border_active), .line_start(line_start),
    .vertical_flyback(vertical_flyback), .port_byte_select_in(pbs_in), .ext_data_port(ext_data_port),
    .ext_port_clock(ext_port_clock), .port_byte_select(pbs_out), .cursor_upper_en(cursor_upper_en),
    .cursor_lower_en(cursor_lower_en));

  panel_model panel_u (.pclk(pclk), .port_byte_select(pbs_out), .ext_port_clock(ext_port_clock),
    .port_byte_select_in(pbs_in), .clk_rises(clk_rises));

  always #20 pclk = ~pclk;

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs about five hundred cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  function automatic pix_out_pkg::pix_in_type mk(input int i);
    mk = {8'(i*29+3), 8'(i*53+7), 8'(i*71+11), 4'(i*5+1), 8'(i*97+13)};
  endfunction

  // Mode 4 is hi-res: each cursor pair either passes two blue bits or forces its msb;
  // mode 5 is select 3 with the ext nibble delayed by one pixel
  function automatic logic [7:0] expect_of(input int m, input pix_out_pkg::pix_in_type p);
    case (m)
      0: expect_of = p.red;
      1: expect_of = p.green;
      2: expect_of = p.blue;
      3, 5: expect_of = {4'hA, p.ext};
      default: begin
        for (int k = 0; k < 4; k++)
          expect_of[2*k +: 2] = p.cursor[2*k] ? {2{p.cursor[2*k+1]}} : p.blue[2*k +: 2];
      end
    endcase
  endfunction

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    check("port_reset", ext_data_port, 0);
    apb(0, pix_out_pkg::OFS_EXT, 0, r, e);
    check("ext_reset", r, pix_out_pkg::EXT_RST);
    apb(0, pix_out_pkg::OFS_CTRL, 0, r, e);
    check("ctrl_reset", r, pix_out_pkg::CTRL_RST);
    apb(0, pix_out_pkg::OFS_VCS, 0, r, e);
    check("vcs_reset", r, pix_out_pkg::VC_RST);
    apb(1, 8'h18, 32'hFFFF_FFFF, r, e);
    check("unmapped_err", e, 1);
    apb(0, 8'h18, 0, r, e);
    check("unmapped_data", r, 0);
    apb(1, pix_out_pkg::OFS_EXT, 32'h0000_2000, r, e);
    apb(0, pix_out_pkg::OFS_EXT, 0, r, e);
    check("ext_lcd_bit", r, 32'h0000_2000);
    apb(1, pix_out_pkg::OFS_CTRL, 32'h0000_2000, r, e);
    apb(0, pix_out_pkg::OFS_CTRL, 0, r, e);
    check("ctrl_dup_bit", r, 32'h0000_2000);
    $display("test regs done");
  endtask

  task automatic t_stream(input int m);
    int          lat;
    logic [31:0] r;
    logic        e, prev;
    logic [7:0]  x_exp;
    lat = (m >= 4) ? 2 : 1;
    apb(1, pix_out_pkg::OFS_EXT, (m == 4) ? 32'h0000_10A6 : (m == 5) ? 32'h0000_40A3 : 32'h0000_00A0 | 32'(m), r, e);
    if (m == 4) apb(1, pix_out_pkg::OFS_BORDER, 32'h0000_005C, r, e);
    cyc(4);
    display_active <= 1'b1;
    for (int i = 0; i < 6 + lat; i++) begin
      @(posedge pclk);
      if (i < 6) begin
        pix_in <= mk(i);
        border_active <= (m == 4 && i == 3);
      end
      #1;
      if (i >= lat) begin
        x_exp = (m == 4 && i == lat + 3) ? 8'h5C : expect_of(m, mk(i - lat));
        check($sformatf("port_mode%0d", m), ext_data_port, x_exp);
      end
      if (m == 4 && i > lat) check("hires_clock", ext_port_clock, !prev);
      prev = ext_port_clock;
    end
    display_active <= 1'b0;
    $display("test stream mode %0d done", m);
  endtask

  task automatic raster_to(input int n, input logic [1:0] exp, input string what);
    vertical_flyback <= 1'b1;
    cyc(2);
    vertical_flyback <= 1'b0;
    repeat (n) begin
      @(posedge pclk);
      line_start <= 1'b1;
      @(posedge pclk);
      line_start <= 1'b0;
    end
    cyc(3);
    #1;
    check(what, {cursor_upper_en, cursor_lower_en}, exp);
  endtask

  task automatic t_cursor();
    logic [31:0] r;
    logic        e, prev_f, new_f, seen;
    apb(1, pix_out_pkg::OFS_CTRL, 32'h0000_2000, r, e);
    apb(1, pix_out_pkg::OFS_VCE, 32'd12, r, e);
    apb(1, pix_out_pkg::OFS_VCS, 32'h0000_4004, r, e);
    raster_to(8, 2'b10, "upper_mid");
    raster_to(16, 2'b00, "upper_after");
    apb(1, pix_out_pkg::OFS_VCS, 32'h0000_2004, r, e);
    raster_to(8, 2'b01, "lower_mid");
    apb(1, pix_out_pkg::OFS_VCS, 32'h0000_6004, r, e);
    raster_to(2, 2'b01, "split_top");
    raster_to(8, 2'b00, "split_mid");
    raster_to(16, 2'b10, "split_end");
    apb(1, pix_out_pkg::OFS_CTRL, 32'h0000_4000, r, e);
    apb(1, pix_out_pkg::OFS_VCS, 32'd4, r, e);
    apb(0, pix_out_pkg::OFS_STATUS, 0, r, e);
    prev_f = r[15];
    seen = 1'b0;
    // Three retraces always include one odd-to-even change and a later odd field.
    // The bench stands for the memory controller: its pointer reloads only at these retraces.
    repeat (3) begin
      new_f = !prev_f;
      if (prev_f && !new_f) seen = 1'b1;
      raster_to(8, {seen, 1'b0}, "interlace_cursor");
      apb(0, pix_out_pkg::OFS_STATUS, 0, r, e);
      check("field_parity", r[15], new_f);
      prev_f = new_f;
    end
    $display("test cursor done");
  endtask

  // Four rasters of one quad each cover every dither row and column once
  task automatic t_lcd(input logic [3:0] g, input logic [3:0] x, input logic dup, input logic [2:0] bpp,
                       input logic fo);
    int          up, lo, r0;
    logic [31:0] r;
    logic        e;
    apb(1, pix_out_pkg::OFS_CTRL, {18'h0, dup, 10'h0, bpp}, r, e);
    apb(1, pix_out_pkg::OFS_EXT, 32'h0000_2005, r, e);
    vertical_flyback <= 1'b1;
    cyc(2);
    vertical_flyback <= 1'b0;
    pix_in <= {8'h00, 4'hC, g, 8'h00, x, 8'h00};
    up = 0;
    lo = 0;
    r0 = clk_rises;
    repeat (4) begin
      @(posedge pclk);
      line_start <= 1'b1;
      @(posedge pclk);
      line_start <= 1'b0;
      display_active <= 1'b1;
      for (int c = 0; c < 4; c++) begin
        pix_in.green <= {4'hC, (fo && c > 0) ? 4'h0 : g};
        @(posedge pclk);
      end
      display_active <= 1'b0;
      @(posedge pclk);
      #1;
      up += $countones(ext_data_port[7:4]);
      lo += $countones(ext_data_port[3:0]);
      if (!dup) check("single_low", ext_data_port[3:0], 0);
      if (fo) check("later_pixels", ext_data_port[6:4], 0);
    end
    if (dup && bpp > 3'h2) begin
      check("deep_dual", up + lo, 0);
    end else if (fo) begin
      check("first_pixel", up >= 3, 1);
    end else begin
      check("upper_duty", up, g);
      check("lower_duty", lo, dup ? x : 4'h0);
      check("lcd_clock", clk_rises - r0, 4);
    end
    $display("test lcd done");
  endtask

  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pix_in = '0;
    display_active = 0;
    border_active = 0;
    line_start = 0;
    vertical_flyback = 0;
    error_cnt = 0;
    n_compared = 0;
    cycles = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    for (int m = 0; m < 6; m++) t_stream(m);
    t_cursor();
    t_lcd(4'h9, 4'h0, 1'b0, pix_out_pkg::BPP_4, 1'b0);
    t_lcd(4'h5, 4'hB, 1'b1, pix_out_pkg::BPP_1, 1'b0);
    t_lcd(4'hF, 4'h0, 1'b0, pix_out_pkg::BPP_4, 1'b1);
    t_lcd(4'h7, 4'h6, 1'b1, 3'h3, 1'b0);
    stop_test();
  end
endmodule // tb_cursor_lcd_hires_output
`default_nettype wire
